// ---- src/primary_timer.sv ----
// Purpose: primary_timer, 16-bit timer/counter with capcomp time-base links
// Assumes: clk is the oscillator clock; pin inputs synchronous to clk
// Notes: registers reached over Avalon-MM with waitrequest
// How it works
// - sixteen-bit counter as two software bytes
// - special trigger clears the unit's time base
// - bit zero runs or halts counting
// - bit seven selects atomic sixteen-bit access
// - bit three enables the timer oscillator
// - bit two bypasses external input synchronisation
// - bit one selects external rising edges
// - each unit has control and data bytes
// - capture/compare use timer; PWM uses pwm_timebase
// - secondary control selection bits assign time bases (capture only here; compare triggers ignore them)
// - no capture in unsynchronised external mode
// - fuse routes unit b pin C1 or B3
// - only unit b trigger starts conversion
// - both PWM units share timebase overflow
// - PWM and capture units stay independent
//
// Added by the designer: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
module primary_timer
	import tmr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// avalon-mm slave
	input wire logic [4:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// pins and neighbours
	input wire logic external_count_input,
	input wire logic sysclk_sel_timer_osc,
	input wire logic unit_b_pin_route_fuse,
	input wire logic [1:0] secondary_timer_select,
	input wire logic pwm_timebase_overflow,
	input wire logic capture_event_a,
	input wire logic capture_event_b,
	// outputs
	output logic timer_osc_enable,
	output logic overflow_irq,
	output logic adc_start,
	output logic pwm_update,
	output logic unit_b_on_port_c_line_1,
	output logic unit_b_on_port_b_line_3
);
	// ==================================================
	// state
	logic [7:0] control_reg, control_next; // timer_control writable bits
	count_t count_reg, count_next; // live counter
	logic [7:0] high_buf_reg, high_buf_next; // atomic high-byte buffer
	logic [2:0] ps_reg, ps_next; // prescaler
	logic [1:0] idiv_reg, idiv_next; // instruction clock divider
	logic ext_s_reg, ext_s_next; // synchronised pin
	logic ext_d_reg, ext_d_next; // previous pin level
	logic ovf_reg, ovf_next; // overflow flag
	logic ovf_en_reg, ovf_en_next; // overflow request enable
	logic irq_reg, irq_next;
	logic [3:0] ua_ctrl_reg, ua_ctrl_next;
	logic [3:0] ub_ctrl_reg, ub_ctrl_next;
	logic [15:0] ua_data_reg, ua_data_next;
	logic [15:0] ub_data_reg, ub_data_next;
	logic adc_reg, adc_next;
	logic pwm_reg, pwm_next;
	logic wait_reg, wait_next; // one wait state per access
	logic wreq_reg, wreq_next; // registered waitrequest, high while idle
	logic [31:0] rdata_reg, rdata_next;
	logic osc_run_reg, osc_run_next;
	logic pc1_reg, pb3_reg;
	// ==================================================
	// combinational helpers
	logic sel_ext, ext_edge, base_tick, ps_tick, tick;
	logic take, peek, trig_a, trig_b, clear_req, cap_ok;
	logic [16:0] inc;
	always_comb begin
		sel_ext = control_reg[BIT_SRC];
		// bypass looks at the raw pin, else at the synchronised copy
		ext_edge = control_reg[BIT_SYNC_BYP] ? (external_count_input & ~ext_d_reg)
			: (ext_s_reg & ~ext_d_reg);
		base_tick = sel_ext ? ext_edge : (idiv_reg == INSTR_DIV);
		case (control_reg[BIT_PS_LO+1:BIT_PS_LO])
			2'h0: ps_tick = base_tick;
			2'h1: ps_tick = base_tick & (ps_reg[0] == 1'b1);
			2'h2: ps_tick = base_tick & (ps_reg[1:0] == 2'h3);
			default: ps_tick = base_tick & (ps_reg == 3'h7);
		endcase
		tick = ps_tick & control_reg[BIT_RUN];
		inc = {1'b0, count_reg} + 17'h00001;
		take = (read | write) & wait_reg;
		// read data launches one edge early so it stands at the take edge
		peek = read & ~wait_reg;
		// a trigger needs compare mode, trigger enable and timer use
		trig_a = (ua_ctrl_reg[1:0] == MODE_COMPARE) & ua_ctrl_reg[3] & ~ua_ctrl_reg[2]
			& ({count_reg} == ua_data_reg);
		trig_b = (ub_ctrl_reg[1:0] == MODE_COMPARE) & ub_ctrl_reg[3] & ~ub_ctrl_reg[2]
			& ({count_reg} == ub_data_reg);
		clear_req = trig_a | trig_b;
		cap_ok = ~(sel_ext & control_reg[BIT_SYNC_BYP]);
	end
	// ==================================================
	// next-state logic
	always_comb begin
		control_next = control_reg;
		count_next = count_reg;
		high_buf_next = high_buf_reg;
		ps_next = ps_reg;
		idiv_next = idiv_reg + 2'h1;
		ext_s_next = external_count_input;
		ext_d_next = control_reg[BIT_SYNC_BYP] ? external_count_input : ext_s_reg;
		ovf_next = ovf_reg;
		ovf_en_next = ovf_en_reg;
		ua_ctrl_next = ua_ctrl_reg;
		ub_ctrl_next = ub_ctrl_reg;
		ua_data_next = ua_data_reg;
		ub_data_next = ub_data_reg;
		adc_next = trig_b;
		pwm_next = pwm_timebase_overflow;
		osc_run_next = sysclk_sel_timer_osc;
		wait_next = (read | write) & ~wait_reg;
		wreq_next = ~wait_next;
		rdata_next = 32'h00000000;
		if (base_tick) begin
			ps_next = ps_reg + 3'h1;
		end
		// counting, with the trigger clear taking priority
		if (clear_req) begin
			count_next = 16'h0000;
		end else if (tick) begin
			count_next = inc[15:0];
		end
		// units pick the primary timer only when select bit clear
		// the secondary select input forces the choice per unit
		if (cap_ok && ua_ctrl_reg[1:0] == MODE_CAPTURE && ~(ua_ctrl_reg[2] | secondary_timer_select[0])
			&& capture_event_a) begin
			ua_data_next = count_reg;
		end
		if (cap_ok && ub_ctrl_reg[1:0] == MODE_CAPTURE && ~(ub_ctrl_reg[2] | secondary_timer_select[1])
			&& capture_event_b) begin
			ub_data_next = count_reg;
		end
		// register access
		if (take && write) begin
			case (address)
				OFF_CONTROL: control_next = writedata[7:0] & 8'hBF;
				OFF_COUNT_LOW: begin
					count_next.low = writedata[7:0];
					if (control_reg[BIT_ATOMIC]) begin
						count_next.high = high_buf_reg;
					end
				end
				OFF_COUNT_HIGH: begin
					if (control_reg[BIT_ATOMIC]) begin
						high_buf_next = writedata[7:0];
					end else begin
						count_next.high = writedata[7:0];
					end
				end
				OFF_STATUS: ovf_en_next = writedata[1];
				OFF_UNIT_A_CTRL: ua_ctrl_next = writedata[3:0];
				OFF_UNIT_A_DATA: ua_data_next = writedata[15:0];
				OFF_UNIT_B_CTRL: ub_ctrl_next = writedata[3:0];
				OFF_UNIT_B_DATA: ub_data_next = writedata[15:0];
				default: ;
			endcase
		end
		// overflow flag: write-one clear, set wins
		if (take && write && address == OFF_STATUS && writedata[0]) begin
			ovf_next = 1'b0;
		end
		if (tick && !clear_req && inc[16]) begin
			ovf_next = 1'b1;
		end
		if (peek) begin
			case (address)
				OFF_CONTROL: rdata_next = {24'h000000, control_reg[7], osc_run_reg, control_reg[5:0]};
				OFF_COUNT_LOW: rdata_next = {24'h000000, count_reg.low};
				OFF_COUNT_HIGH: rdata_next = {24'h000000,
					control_reg[BIT_ATOMIC] ? high_buf_reg : count_reg.high};
				OFF_STATUS: rdata_next = {30'h00000000, ovf_en_reg, ovf_reg};
				OFF_UNIT_A_CTRL: rdata_next = {28'h0000000, ua_ctrl_reg};
				OFF_UNIT_A_DATA: rdata_next = {16'h0000, ua_data_reg};
				OFF_UNIT_B_CTRL: rdata_next = {28'h0000000, ub_ctrl_reg};
				OFF_UNIT_B_DATA: rdata_next = {16'h0000, ub_data_reg};
				default: rdata_next = 32'h00000000;
			endcase
			// low read latches the high byte for a torn-free pair
			if (address == OFF_COUNT_LOW && control_reg[BIT_ATOMIC]) begin
				high_buf_next = count_reg.high;
			end
		end
		irq_next = ovf_next & ovf_en_next;
	end
	// ==================================================
	// registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			control_reg <= CONTROL_RESET;
			count_reg <= '0;
			high_buf_reg <= 8'h00;
			ps_reg <= 3'h0;
			idiv_reg <= 2'h0;
			ext_s_reg <= 1'b0;
			ext_d_reg <= 1'b0;
			ovf_reg <= 1'b0;
			ovf_en_reg <= 1'b0;
			irq_reg <= 1'b0;
			ua_ctrl_reg <= 4'h0;
			ub_ctrl_reg <= 4'h0;
			ua_data_reg <= 16'h0000;
			ub_data_reg <= 16'h0000;
			adc_reg <= 1'b0;
			pwm_reg <= 1'b0;
			wait_reg <= 1'b0;
			wreq_reg <= 1'b1;
			rdata_reg <= 32'h00000000;
			osc_run_reg <= 1'b0;
			pc1_reg <= 1'b0;
			pb3_reg <= 1'b0;
		end else begin
			control_reg <= control_next;
			count_reg <= count_next;
			high_buf_reg <= high_buf_next;
			ps_reg <= ps_next;
			idiv_reg <= idiv_next;
			ext_s_reg <= ext_s_next;
			ext_d_reg <= ext_d_next;
			ovf_reg <= ovf_next;
			ovf_en_reg <= ovf_en_next;
			irq_reg <= irq_next;
			ua_ctrl_reg <= ua_ctrl_next;
			ub_ctrl_reg <= ub_ctrl_next;
			ua_data_reg <= ua_data_next;
			ub_data_reg <= ub_data_next;
			adc_reg <= adc_next;
			pwm_reg <= pwm_next;
			wait_reg <= wait_next;
			wreq_reg <= wreq_next;
			rdata_reg <= rdata_next;
			osc_run_reg <= osc_run_next;
			pc1_reg <= unit_b_pin_route_fuse;
			pb3_reg <= ~unit_b_pin_route_fuse;
		end
	end
	// ==================================================
	// outputs, all from flip-flops
	always_comb begin
		readdata = rdata_reg;
		waitrequest = wreq_reg;
		timer_osc_enable = control_reg[BIT_OSC_EN];
		overflow_irq = irq_reg;
		adc_start = adc_reg;
		pwm_update = pwm_reg;
		unit_b_on_port_c_line_1 = pc1_reg;
		unit_b_on_port_b_line_3 = pb3_reg;
	end
	// ==================================================
	// checks
	property p_clear;
		@(posedge clk) disable iff (!nrst) clear_req |=> count_reg == 16'h0000;
	endproperty
	a_clear: assert property (p_clear) else $error("trigger did not clear counter");
	property p_halt;
		@(posedge clk) disable iff (!nrst) (!control_reg[BIT_RUN] && !clear_req && !(take && write))
			|=> $stable(count_reg);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted");
	property p_ovf;
		@(posedge clk) disable iff (!nrst) (tick && !clear_req && count_reg == 16'hFFFF) |=> ovf_reg;
	endproperty
	a_ovf: assert property (p_ovf) else $error("rollover missed overflow flag");
	property p_irq;
		@(posedge clk) disable iff (!nrst) overflow_irq |-> $past(ovf_en_next);
	endproperty
	a_irq: assert property (p_irq) else $error("request raised while disabled");
	property p_int_rate;
		@(posedge clk) disable iff (!nrst) (tick && !sel_ext && control_reg[5:4] == 2'h0 && $stable(control_reg))
			|=> !tick [*3];
	endproperty
	a_int_rate: assert property (p_int_rate) else $error("internal count faster than quarter rate");
	property p_adc;
		@(posedge clk) disable iff (!nrst) adc_start |-> $past(trig_b);
	endproperty
	a_adc: assert property (p_adc) else $error("conversion start without unit b trigger");
	property p_route;
		@(posedge clk) disable iff (!nrst) $past(nrst) |-> (unit_b_on_port_c_line_1 != unit_b_on_port_b_line_3);
	endproperty
	a_route: assert property (p_route) else $error("unit b routed to both or no pins");
	property p_osc;
		@(posedge clk) disable iff (!nrst) (take && write && address == OFF_CONTROL)
			|=> timer_osc_enable == $past(writedata[BIT_OSC_EN]);
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator enable mismatch");
	property p_wait;
		@(posedge clk) disable iff (!nrst) (read || write) && waitrequest |=> !waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("slave did not answer in one cycle");
	c_ovf: cover property (@(posedge clk) disable iff (!nrst) $rose(ovf_reg));
	c_clear: cover property (@(posedge clk) disable iff (!nrst) clear_req);
	c_ext: cover property (@(posedge clk) disable iff (!nrst) sel_ext && tick);
	c_cap: cover property (@(posedge clk) disable iff (!nrst) ua_data_next != ua_data_reg && !(take && write));
endmodule

// ---- src/tmr_pkg.sv ----
// Purpose: constants and carriers for the primary timer block
// Assumes: 32-bit Avalon-MM word registers, byte addresses
// Notes: control bit positions follow the timer_control layout
package tmr_pkg;
	// ==================================================
	// register offsets (byte addresses)
	localparam logic [4:0] OFF_CONTROL = 5'h00; // timer_control
	localparam logic [4:0] OFF_COUNT_LOW = 5'h04; // count_low_byte
	localparam logic [4:0] OFF_COUNT_HIGH = 5'h08; // count_high_byte
	localparam logic [4:0] OFF_STATUS = 5'h0C; // overflow flag and enable
	localparam logic [4:0] OFF_UNIT_A_CTRL = 5'h10; // capcomp_unit_a control
	localparam logic [4:0] OFF_UNIT_A_DATA = 5'h14; // capcomp_unit_a data
	localparam logic [4:0] OFF_UNIT_B_CTRL = 5'h18; // capcomp_unit_b control
	localparam logic [4:0] OFF_UNIT_B_DATA = 5'h1C; // capcomp_unit_b data
	// ==================================================
	// control field positions
	localparam int BIT_RUN = 0;
	localparam int BIT_SRC = 1;
	localparam int BIT_SYNC_BYP = 2;
	localparam int BIT_OSC_EN = 3;
	localparam int BIT_PS_LO = 4;
	localparam int BIT_OSC_RUN = 6;
	localparam int BIT_ATOMIC = 7;
	// capcomp_control fields: [1:0] mode, [2] timer select, [3] trigger enable
	localparam logic [1:0] MODE_OFF = 2'h0;
	localparam logic [1:0] MODE_CAPTURE = 2'h1;
	localparam logic [1:0] MODE_COMPARE = 2'h2;
	localparam logic [1:0] MODE_PWM = 2'h3;
	// ==================================================
	// reset values and counts
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [1:0] INSTR_DIV = 2'h3; // quarter rate: count 0..3
	// ==================================================
	// carrier for the counter pair
	typedef struct packed {
		logic [7:0] high;
		logic [7:0] low;
	} count_t;
endpackage

// ---- sim/count_source_model.sv ----
// Purpose: far-side model, external count pin and pwm overflow source
// Assumes: gap of two or more keeps each pin level three cycles or longer
// Notes: pin rests low between bursts, so no stray edge is counted
`timescale 1ns/1ps
module count_source_model (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// requests from the bench
	input wire logic burst_go,
	input wire logic [7:0] burst_len,
	input wire logic [3:0] gap,
	input wire logic pwm_go,
	// far-side pins
	output logic ext_pin,
	output logic pwm_ovf,
	output logic busy
);
	logic [8:0] half_left; // half periods still to send
	logic [3:0] wait_cnt; // cycles before the next pin change
	assign busy = (half_left != 9'h000);
	// ==================================================
	// burst engine: slow or prompt edges, chosen by gap
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ext_pin <= 1'b0;
			pwm_ovf <= 1'b0;
			half_left <= 9'h000;
			wait_cnt <= 4'h0;
		end else begin
			pwm_ovf <= pwm_go; // one-cycle overflow pulse
			if (burst_go) begin
				half_left <= {burst_len, 1'b0};
				wait_cnt <= gap;
			end else if (busy) begin
				if (wait_cnt == 4'h0) begin
					ext_pin <= ~ext_pin;
					half_left <= half_left - 9'h001;
					wait_cnt <= gap;
				end else begin
					wait_cnt <= wait_cnt - 4'h1;
				end
			end
		end
	end
endmodule

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for primary_timer
// Assumes: one wait state per access, counter tick every four clocks
// Notes: rate checks allow one count of slack for read latency
`timescale 1ns/1ps
module tb_top
	import tmr_pkg::*;
;
	logic clk, nrst, read, write, sysclk_sel, fuse, burst_go, pwm_go, ext_pin, pwm_ovf, busy;
	logic osc_en, irq, adc_start, pwm_update, on_c1, on_b3, waitrequest;
	logic [4:0] address;
	logic [31:0] writedata, readdata, rd;
	logic [1:0] sel;
	logic [7:0] burst_len, v;
	logic [3:0] gap;
	logic cap_a, cap_b; // capture strobes
	logic [31:0] w; // random word kept off the bus pins
	int err_count, cmp_count, n;
	primary_timer DUT (.clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.external_count_input(ext_pin), .sysclk_sel_timer_osc(sysclk_sel), .unit_b_pin_route_fuse(fuse),
		.secondary_timer_select(sel), .pwm_timebase_overflow(pwm_ovf), .capture_event_a(cap_a),
		.capture_event_b(cap_b), .timer_osc_enable(osc_en), .overflow_irq(irq), .adc_start(adc_start),
		.pwm_update(pwm_update), .unit_b_on_port_c_line_1(on_c1), .unit_b_on_port_b_line_3(on_b3));
	count_source_model partner (.clk(clk), .nrst(nrst), .burst_go(burst_go), .burst_len(burst_len),
		.gap(gap), .pwm_go(pwm_go), .ext_pin(ext_pin), .pwm_ovf(pwm_ovf), .busy(busy));
	// ==================================================
	// clock, watchdog and shared tasks
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++; // hang counts as a mismatch
		complete_run();
	end
	task complete_run;
		$display("counts: compares %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task check(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", name, exp, got);
			err_count++;
		end
	endtask
	// one access, held until waitrequest is seen low
	task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= ~wr;
		do begin
			@(posedge clk);
			k++;
		end while (waitrequest !== 1'b0 && k < 40);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (k >= 40) check("waitrequest", 32'h0, 32'h1);
	endtask
	task rd_chk(input string name, input logic [4:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(name, exp, rd);
	endtask
	// one-cycle capture strobe per set bit: [0] unit a, [1] unit b
	task pulse_cap(input logic [1:0] m);
		@(posedge clk);
		{cap_b, cap_a} <= m;
		@(posedge clk);
		{cap_b, cap_a} <= 2'h0;
	endtask
	// counter from zero with given unit controls, trigger at 0x20
	task trig(input logic [3:0] ca, input logic [3:0] cb, input logic adc_on, input logic cleared);
		int pulses;
		pulses = 0;
		bus(1'b1, OFF_CONTROL, 32'h0);
		bus(1'b1, OFF_COUNT_LOW, 32'h0);
		bus(1'b1, OFF_COUNT_HIGH, 32'h0);
		bus(1'b1, OFF_UNIT_A_DATA, 32'h20);
		bus(1'b1, OFF_UNIT_B_DATA, 32'h20);
		bus(1'b1, OFF_UNIT_A_CTRL, {28'h0, ca});
		bus(1'b1, OFF_UNIT_B_CTRL, {28'h0, cb});
		bus(1'b1, OFF_CONTROL, 32'h1);
		repeat (400) begin
			@(posedge clk);
			#1;
			if (adc_start === 1'b1) pulses++;
		end
		bus(1'b1, OFF_CONTROL, 32'h0);
		bus(1'b0, OFF_COUNT_LOW, 32'h0);
		check("adc start seen", {31'h0, adc_on}, {31'h0, pulses != 0});
		check("count cleared", {31'h0, cleared}, {31'h0, rd[7:0] <= 8'h21});
	endtask
	// ==================================================
	// main sequence
	initial begin
		{address, read, write, writedata, sysclk_sel, sel, burst_go, burst_len, pwm_go, cap_a, cap_b} = '0;
		fuse = 1'b1;
		gap = 4'h2;
		nrst = 1'b0;
		void'($urandom(32'h419DE0F5));
		repeat (4) @(posedge clk);
		nrst <= 1'b1;
		rd_chk("control reset", OFF_CONTROL, {24'h0, CONTROL_RESET});
		rd_chk("count reset", OFF_COUNT_LOW, 32'h0);
		for (int i = 0; i < 6; i++) begin
			v = 8'($urandom);
			sysclk_sel <= 1'($urandom);
			bus(1'b1, OFF_CONTROL, {24'h0, v});
			rd_chk("control", OFF_CONTROL, {24'h0, v[7], sysclk_sel, v[5:0]});
			check("osc enable", {31'h0, v[3]}, {31'h0, osc_en});
		end
		for (int j = 0; j < 4; j++) begin
			w = $urandom;
			v = 8'(OFF_UNIT_A_CTRL) + 8'(j * 4);
			bus(1'b1, v[4:0], w);
			rd_chk("unit register", v[4:0], w & (j[0] ? 32'hFFFF : 32'hF));
		end
		// random unit controls could arm a trigger that clears the counter later
		bus(1'b1, OFF_UNIT_A_CTRL, 32'h0);
		bus(1'b1, OFF_UNIT_B_CTRL, 32'h0);
		$display("test registers done");
		for (int p = 0; p < 4; p++) begin
			bus(1'b1, OFF_CONTROL, 32'h0);
			bus(1'b1, OFF_CONTROL, 32'h1 | (p << 4));
			bus(1'b0, OFF_COUNT_LOW, 32'h0);
			v = rd[7:0];
			repeat (32 * (4 << p)) @(posedge clk);
			bus(1'b0, OFF_COUNT_LOW, 32'h0);
			v = rd[7:0] - v;
			check("prescale rate", 32'h1, {31'h0, v >= 8'h1F && v <= 8'h21});
		end
		bus(1'b1, OFF_CONTROL, 32'h0);
		bus(1'b0, OFF_COUNT_LOW, 32'h0);
		repeat (100) @(posedge clk);
		rd_chk("halted count", OFF_COUNT_LOW, rd);
		$display("test rate done");
		bus(1'b1, OFF_CONTROL, 32'h80);
		bus(1'b1, OFF_COUNT_HIGH, 32'h34);
		bus(1'b1, OFF_COUNT_LOW, 32'h56);
		rd_chk("atomic low", OFF_COUNT_LOW, 32'h56);
		rd_chk("atomic high", OFF_COUNT_HIGH, 32'h34);
		bus(1'b1, OFF_COUNT_HIGH, 32'h77);
		rd_chk("atomic low", OFF_COUNT_LOW, 32'h56);
		rd_chk("buffered high", OFF_COUNT_HIGH, 32'h34);
		bus(1'b1, OFF_CONTROL, 32'h0);
		bus(1'b1, OFF_COUNT_HIGH, 32'h77);
		rd_chk("byte high", OFF_COUNT_HIGH, 32'h77);
		$display("test atomic done");
		bus(1'b1, OFF_COUNT_LOW, 32'hFC);
		bus(1'b1, OFF_COUNT_HIGH, 32'hFF);
		bus(1'b1, OFF_STATUS, 32'h2);
		bus(1'b1, OFF_CONTROL, 32'h1);
		repeat (40) @(posedge clk);
		bus(1'b1, OFF_CONTROL, 32'h0);
		rd_chk("overflow flag", OFF_STATUS, 32'h3);
		check("irq raised", 32'h1, {31'h0, irq});
		bus(1'b1, OFF_STATUS, 32'h3);
		rd_chk("flag cleared", OFF_STATUS, 32'h2);
		repeat (2) @(posedge clk);
		check("irq cleared", 32'h0, {31'h0, irq});
		$display("test overflow done");
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, OFF_CONTROL, 32'h0);
			bus(1'b1, OFF_COUNT_LOW, 32'h0);
			bus(1'b1, OFF_CONTROL, {29'h0, i[0], 2'h3});
			@(posedge clk);
			burst_len <= 8'($urandom_range(40, 1));
			gap <= 4'($urandom_range(9, 2));
			burst_go <= 1'b1;
			@(posedge clk);
			burst_go <= 1'b0;
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (busy && n < 1000);
			repeat (6) @(posedge clk);
			rd_chk("external edges", OFF_COUNT_LOW, {24'h0, burst_len});
		end
		$display("test external done");
		trig(4'h0, 4'hA, 1'b1, 1'b1);
		trig(4'hA, 4'h0, 1'b0, 1'b1);
		trig(4'hE, 4'h0, 1'b0, 1'b0);
		$display("test trigger done");
		// capture of a halted counter, then a redirected unit and a blocked source
		bus(1'b1, OFF_COUNT_LOW, 32'h5A);
		bus(1'b1, OFF_UNIT_A_CTRL, 32'h1);
		bus(1'b1, OFF_UNIT_B_CTRL, 32'h1);
		sel <= 2'h2;
		pulse_cap(2'h3);
		rd_chk("capture a", OFF_UNIT_A_DATA, 32'h5A);
		rd_chk("capture b on secondary", OFF_UNIT_B_DATA, 32'h20);
		sel <= 2'h0;
		bus(1'b1, OFF_CONTROL, 32'h6);
		bus(1'b1, OFF_COUNT_LOW, 32'h3C);
		pulse_cap(2'h3);
		rd_chk("capture blocked", OFF_UNIT_A_DATA, 32'h5A);
		bus(1'b1, OFF_CONTROL, 32'h2);
		pulse_cap(2'h2);
		rd_chk("capture b", OFF_UNIT_B_DATA, 32'h3C);
		bus(1'b1, OFF_CONTROL, 32'h0);
		$display("test capture done");
		@(posedge clk);
		pwm_go <= 1'b1;
		@(posedge clk);
		pwm_go <= 1'b0;
		@(posedge clk);
		#1;
		check("pwm update", 32'h1, {31'h0, pwm_update});
		for (int f = 0; f < 2; f++) begin
			fuse <= f[0];
			repeat (3) @(posedge clk);
			check("route c1", {31'h0, f[0]}, {31'h0, on_c1});
			check("route b3", {31'h0, ~f[0]}, {31'h0, on_b3});
		end
		$display("test pwm and route done");
		complete_run();
	end
endmodule
